// file: verilog/mda_cfg.svh
// Constants for the multiply, divide and accumulate unit.
`ifndef MDA_CFG_SVH
`define MDA_CFG_SVH

// ----------------------------------------
// Register offsets on the Wishbone bus
// ----------------------------------------
`define MDA_ADR_STATUS  8'h00
`define MDA_ADR_MASK    8'h04
`define MDA_ADR_BOT_LO  8'h08
`define MDA_ADR_BOT_HI  8'h0c
`define MDA_ADR_TOP_LO  8'h10
`define MDA_ADR_TOP_HI  8'h14

// ----------------------------------------
// Event bits in status and mask
// ----------------------------------------
`define MDA_EV_W        3
`define MDA_EV_DIV      0
`define MDA_EV_ACC      1
`define MDA_EV_RSV      2
`define MDA_MASK_RST    3'h0

// ----------------------------------------
// Clamp limits and divider timing
// ----------------------------------------
`define MDA_POS_LIMIT   64'h0000_0000_7fff_ffff
`define MDA_NEG_LIMIT   64'hffff_ffff_8000_0000
`define MDA_UNS_LIMIT   64'hffff_ffff_ffff_ffff
`define MDA_S32_MAX     34'h0_7fff_ffff
`define MDA_S32_MIN     34'h3_8000_0000
`define MDA_DIV_STEPS   6'h20

`endif

// file: verilog/mda_pkg.sv
// Types shared by the multiply, divide and accumulate unit.
package mda_pkg;

	// Operations the issue logic can hand to the unit.
	typedef enum logic [2:0] {
		MDA_OP_WORD_QUOTIENT,
		MDA_OP_UNSIGNED_WORD_QUOTIENT,
		MDA_OP_DOUBLE_MUL_ACCUM,
		MDA_OP_HALFWORD_MUL_ACCUM,
		MDA_OP_READ_TOP,
		MDA_OP_READ_BOTTOM,
		MDA_OP_WRITE_TOP,
		MDA_OP_WRITE_BOTTOM
	} mda_op_t;

	typedef enum logic {
		MDA_DIV_IDLE,
		MDA_DIV_RUN
	} mda_div_st_t;

endpackage

// file: verilog/mda_divider.sv
// Iterative 32-bit signed or unsigned divider, one quotient bit a cycle.
`timescale 1ns/1ps
`include "mda_cfg.svh"

module mda_divider
	import mda_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Request
	input  wire logic        start,
	input  wire logic        signed_op,
	input  wire logic [31:0] dividend,
	input  wire logic [31:0] divisor,
	// Result
	output logic             done_r,
	output logic      [31:0] quo_r,
	output logic      [31:0] rem_r
);

	mda_div_st_t st_r, st_nxt;
	logic [5:0]  cnt_r, cnt_nxt;
	logic [32:0] part_r, part_nxt;
	logic [31:0] shq_r, shq_nxt;
	logic [31:0] dvs_r, dvs_nxt;
	logic        negq_r, negq_nxt;
	logic        negr_r, negr_nxt;
	logic        done_nxt;
	logic [31:0] quo_nxt, rem_nxt;
	logic [32:0] trial;
	logic        a_neg, b_neg;

	// Signs are stripped up front so the loop is a plain unsigned restoring divide.
	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		part_nxt = part_r;
		shq_nxt  = shq_r;
		dvs_nxt  = dvs_r;
		negq_nxt = negq_r;
		negr_nxt = negr_r;
		done_nxt = 1'b0;
		quo_nxt  = quo_r;
		rem_nxt  = rem_r;
		a_neg    = signed_op & dividend[31];
		b_neg    = signed_op & divisor[31];
		trial    = {part_r[31:0], shq_r[31]};
		case (st_r)
			MDA_DIV_IDLE: begin
				if (start) begin
					st_nxt   = MDA_DIV_RUN;
					cnt_nxt  = `MDA_DIV_STEPS;
					part_nxt = 33'h0;
					shq_nxt  = a_neg ? 32'(-dividend) : dividend;
					dvs_nxt  = b_neg ? 32'(-divisor) : divisor;
					negq_nxt = a_neg ^ b_neg;
					negr_nxt = a_neg;
				end
			end
			MDA_DIV_RUN: begin
				// A zero divisor runs to an all-ones quotient, or 1 for a negative signed dividend; no fault is flagged.
				if (trial >= {1'b0, dvs_r}) begin
					part_nxt = trial - {1'b0, dvs_r};
					shq_nxt  = {shq_r[30:0], 1'b1};
				end else begin
					part_nxt = trial;
					shq_nxt  = {shq_r[30:0], 1'b0};
				end
				cnt_nxt = cnt_r - 6'h1;
				if (cnt_r == 6'h1) begin
					st_nxt   = MDA_DIV_IDLE;
					done_nxt = 1'b1;
					quo_nxt  = negq_r ? 32'(-shq_nxt) : shq_nxt;
					rem_nxt  = negr_r ? 32'(-part_nxt[31:0]) : part_nxt[31:0];
				end
			end
			default: st_nxt = MDA_DIV_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r   <= MDA_DIV_IDLE;
			cnt_r  <= 6'h0;
			part_r <= 33'h0;
			shq_r  <= 32'h0;
			dvs_r  <= 32'h0;
			negq_r <= 1'b0;
			negr_r <= 1'b0;
			done_r <= 1'b0;
			quo_r  <= 32'h0;
			rem_r  <= 32'h0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			part_r <= part_nxt;
			shq_r  <= shq_nxt;
			dvs_r  <= dvs_nxt;
			negq_r <= negq_nxt;
			negr_r <= negr_nxt;
			done_r <= done_nxt;
			quo_r  <= quo_nxt;
			rem_r  <= rem_nxt;
		end
	end

endmodule

// file: verilog/mda_mac.sv
// Combinational multiply-accumulate datapath with optional 32-bit clamping.
`timescale 1ns/1ps
`include "mda_cfg.svh"

module mda_mac
	import mda_pkg::*;
(
	// Operands
	input  wire logic [63:0] opa,
	input  wire logic [63:0] opb,
	input  wire logic [63:0] bottom,
	// Variant select
	input  wire logic        half_op,
	input  wire logic        clamp_en,
	input  wire logic        unsigned_select,
	// Result
	output logic      [63:0] sum
);

	logic signed [65:0] wide_prod;
	logic signed [33:0] narrow_prod;
	logic signed [33:0] narrow_sum;
	logic signed [63:0] half_prod;
	logic               ext_a, ext_b;

	always_comb begin
		ext_a       = ~unsigned_select & opa[31];
		ext_b       = ~unsigned_select & opb[31];
		wide_prod   = $signed({ext_a, opa[31:0]}) * $signed({ext_b, opb[31:0]});
		narrow_prod = $signed({~unsigned_select & opa[15], opa[15:0]})
			* $signed({~unsigned_select & opb[15], opb[15:0]});
		// Operands are widened first so the product is formed at full width.
		half_prod   = $signed({{48{opa[15]}}, opa[15:0]}) * $signed({{48{opb[15]}}, opb[15:0]});
		if (unsigned_select) begin
			narrow_sum = narrow_prod + $signed({2'h0, bottom[31:0]});
		end else begin
			narrow_sum = narrow_prod + $signed({{2{bottom[31]}}, bottom[31:0]});
		end
		if (half_op) begin
			sum = half_prod + bottom;
		end else if (!clamp_en) begin
			sum = wide_prod[63:0] + bottom;
		end else if (unsigned_select) begin
			// Unsigned sums can only run over the top; there is no lower limit.
			sum = narrow_sum[32] ? `MDA_UNS_LIMIT : {32'h0, narrow_sum[31:0]};
		end else if (narrow_sum > $signed(`MDA_S32_MAX)) begin
			sum = `MDA_POS_LIMIT;
		end else if (narrow_sum < $signed(`MDA_S32_MIN)) begin
			sum = `MDA_NEG_LIMIT;
		end else begin
			sum = {{32{narrow_sum[31]}}, narrow_sum[31:0]};
		end
	end

endmodule

// file: verilog/mda_unit.sv
// Multiply, divide and accumulate unit with its result registers and bus slave.
//
// What this block does
// - Signed divide: quotient bottom, remainder top.
// - Unsigned divide: quotient bottom, remainder top.
// - Divides never fault; zero divisor undefined.
// - Divide uses low 32 bits, results sign-extended.
// - Accumulate variant from clamp, upper, unsigned bits.
// - Clamped: 16-bit product plus bottom, 32-bit.
// - Clamp to signed or unsigned limits.
// - Unclamped: 32-bit product plus bottom, 64-bit.
// - Destination gets top or bottom per upper select.
// - Accumulate: reserved fault in 32-bit user/supervisor.
// - Halfword accumulate: signed 16-bit product plus bottom.
// - Halfword accumulate: reserved fault, never overflow.
`timescale 1ns/1ps
`include "mda_cfg.svh"

module mda_unit
	import mda_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Issue port
	input  wire logic        op_valid,
	input  mda_op_t          op_code,
	input  wire logic [63:0] source_a_reg,
	input  wire logic [63:0] source_b_reg,
	input  wire logic [4:0]  dest_idx,
	input  wire logic        clamp_en,
	input  wire logic        upper_select,
	input  wire logic        unsigned_select,
	input  wire logic        mode_64,
	input  wire logic        kernel_mode,
	// General register write-back and status
	output logic             gpr_we_r,
	output logic      [4:0]  gpr_idx_r,
	output logic      [63:0] gpr_data_r,
	output logic             rsv_exc_r,
	output logic             busy_r,
	output logic             irq_r,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o_r,
	output logic             wb_ack_o_r
);

	// ----------------------------------------
	// Datapath helpers
	// ----------------------------------------
	logic        div_start;
	logic        div_done;
	logic [31:0] div_quo, div_rem;
	logic [63:0] mac_sum;
	logic        half_op;
	logic        priv_ok;
	logic [63:0] lo_r, lo_nxt;
	logic [63:0] hi_r, hi_nxt;

	assign half_op = (op_code == MDA_OP_HALFWORD_MUL_ACCUM);
	assign priv_ok = mode_64 | kernel_mode;

	mda_divider u_div (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.start     (div_start),
		.signed_op (op_code == MDA_OP_WORD_QUOTIENT),
		.dividend  (source_a_reg[31:0]),
		.divisor   (source_b_reg[31:0]),
		.done_r    (div_done),
		.quo_r     (div_quo),
		.rem_r     (div_rem)
	);

	mda_mac u_mac (
		.opa             (source_a_reg),
		.opb             (source_b_reg),
		.bottom          (lo_r),
		.half_op         (half_op),
		.clamp_en        (clamp_en),
		.unsigned_select (unsigned_select),
		.sum             (mac_sum)
	);

	// ----------------------------------------
	// Result registers and issue handling
	// ----------------------------------------
	logic        gpr_we_nxt;
	logic [4:0]  gpr_idx_nxt;
	logic [63:0] gpr_data_nxt;
	logic        rsv_exc_nxt;
	logic        busy_nxt;
	logic [`MDA_EV_W-1:0] ev;

	// Requests offered while busy are dropped; the issue logic keeps the spacing.
	always_comb begin
		lo_nxt       = lo_r;
		hi_nxt       = hi_r;
		gpr_we_nxt   = 1'b0;
		gpr_idx_nxt  = gpr_idx_r;
		gpr_data_nxt = gpr_data_r;
		rsv_exc_nxt  = 1'b0;
		div_start    = 1'b0;
		ev           = '0;
		if (div_done) begin
			lo_nxt          = {{32{div_quo[31]}}, div_quo};
			hi_nxt          = {{32{div_rem[31]}}, div_rem};
			ev[`MDA_EV_DIV] = 1'b1;
		end
		if (op_valid && !busy_r) begin
			case (op_code)
				MDA_OP_WORD_QUOTIENT,
				MDA_OP_UNSIGNED_WORD_QUOTIENT: begin
					div_start = 1'b1;
				end
				MDA_OP_DOUBLE_MUL_ACCUM,
				MDA_OP_HALFWORD_MUL_ACCUM: begin
					if (!priv_ok) begin
						rsv_exc_nxt     = 1'b1;
						ev[`MDA_EV_RSV] = 1'b1;
					end else begin
						// Top is left as it was; the halfword form leaves it undefined.
						lo_nxt          = mac_sum;
						ev[`MDA_EV_ACC] = 1'b1;
						gpr_we_nxt      = !half_op;
						gpr_idx_nxt     = dest_idx;
						gpr_data_nxt    = upper_select ? hi_r : mac_sum;
					end
				end
				MDA_OP_READ_TOP: begin
					gpr_we_nxt   = 1'b1;
					gpr_idx_nxt  = dest_idx;
					gpr_data_nxt = hi_r;
				end
				MDA_OP_READ_BOTTOM: begin
					gpr_we_nxt   = 1'b1;
					gpr_idx_nxt  = dest_idx;
					gpr_data_nxt = lo_r;
				end
				MDA_OP_WRITE_TOP:    hi_nxt = source_a_reg;
				MDA_OP_WRITE_BOTTOM: lo_nxt = source_a_reg;
				default: ;
			endcase
		end
		busy_nxt = div_start | (busy_r & ~div_done);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			lo_r       <= 64'h0;
			hi_r       <= 64'h0;
			gpr_we_r   <= 1'b0;
			gpr_idx_r  <= 5'h0;
			gpr_data_r <= 64'h0;
			rsv_exc_r  <= 1'b0;
			busy_r     <= 1'b0;
		end else begin
			lo_r       <= lo_nxt;
			hi_r       <= hi_nxt;
			gpr_we_r   <= gpr_we_nxt;
			gpr_idx_r  <= gpr_idx_nxt;
			gpr_data_r <= gpr_data_nxt;
			rsv_exc_r  <= rsv_exc_nxt;
			busy_r     <= busy_nxt;
		end
	end

	// ----------------------------------------
	// Wishbone slave, status, mask, interrupt
	// ----------------------------------------
	logic [`MDA_EV_W-1:0] status_r, status_nxt;
	logic [`MDA_EV_W-1:0] mask_r, mask_nxt;
	logic [31:0]          wb_dat_nxt;
	logic                 wb_ack_nxt;
	logic                 irq_nxt;
	logic                 wb_req;

	// A read of status clears it, but an event in the same cycle still lands.
	always_comb begin
		wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o_r;
		wb_ack_nxt = wb_req;
		wb_dat_nxt = 32'h0;
		mask_nxt   = mask_r;
		status_nxt = status_r;
		if (wb_req && !wb_we_i) begin
			if (wb_adr_i == `MDA_ADR_STATUS) begin
				wb_dat_nxt = {29'h0, status_r};
				status_nxt = '0;
			end else if (wb_adr_i == `MDA_ADR_MASK) begin
				wb_dat_nxt = {29'h0, mask_r};
			end else if (wb_adr_i == `MDA_ADR_BOT_LO) begin
				wb_dat_nxt = lo_r[31:0];
			end else if (wb_adr_i == `MDA_ADR_BOT_HI) begin
				wb_dat_nxt = lo_r[63:32];
			end else if (wb_adr_i == `MDA_ADR_TOP_LO) begin
				wb_dat_nxt = hi_r[31:0];
			end else if (wb_adr_i == `MDA_ADR_TOP_HI) begin
				wb_dat_nxt = hi_r[63:32];
			end
		end
		if (wb_req && wb_we_i && wb_adr_i == `MDA_ADR_MASK && wb_sel_i[0]) begin
			mask_nxt = wb_dat_i[`MDA_EV_W-1:0];
		end
		status_nxt = status_nxt | ev;
		irq_nxt    = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			status_r   <= '0;
			mask_r     <= `MDA_MASK_RST;
			wb_dat_o_r <= 32'h0;
			wb_ack_o_r <= 1'b0;
			irq_r      <= 1'b0;
		end else begin
			status_r   <= status_nxt;
			mask_r     <= mask_nxt;
			wb_dat_o_r <= wb_dat_nxt;
			wb_ack_o_r <= wb_ack_nxt;
			irq_r      <= irq_nxt;
		end
	end

endmodule

// file: sim/mda_unit_monitor.sv
// Port-level assertions for the multiply, divide and accumulate unit.
`timescale 1ns/1ps
module mda_unit_monitor
	import mda_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       nrst,
	// Issue port
	input wire logic       op_valid,
	input mda_op_t         op_code,
	input wire logic [4:0] dest_idx,
	input wire logic       mode_64,
	input wire logic       kernel_mode,
	// Results and bus answer
	input wire logic       gpr_we_r,
	input wire logic [4:0] gpr_idx_r,
	input wire logic       rsv_exc_r,
	input wire logic       busy_r,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o_r
);
	logic tk, dv, ac, pv;
	assign tk = op_valid && !busy_r;
	assign dv = op_code inside {MDA_OP_WORD_QUOTIENT, MDA_OP_UNSIGNED_WORD_QUOTIENT};
	assign ac = op_code inside {MDA_OP_DOUBLE_MUL_ACCUM, MDA_OP_HALFWORD_MUL_ACCUM};
	assign pv = mode_64 || kernel_mode;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o_r |=> wb_ack_o_r)
		else $error("bus ack missing");
	chk_wb_pulse: assert property (wb_ack_o_r |=> !wb_ack_o_r)
		else $error("bus ack held");
	chk_div_span: assert property (tk && dv |=> busy_r ##32 busy_r ##1 !busy_r)
		else $error("divide busy span wrong");
	chk_div_quiet: assert property (tk && dv |=> !rsv_exc_r && !gpr_we_r)
		else $error("divide raised a fault");
	chk_acc_dest: assert property (tk && op_code == MDA_OP_DOUBLE_MUL_ACCUM && pv |=>
		gpr_we_r && gpr_idx_r == $past(dest_idx)) else $error("accumulate write-back wrong");
	chk_acc_reserved: assert property (tk && ac && !pv |=> rsv_exc_r && !gpr_we_r)
		else $error("reserved fault missing");
	chk_half_nowrite: assert property (tk && op_code == MDA_OP_HALFWORD_MUL_ACCUM |=> !gpr_we_r)
		else $error("halfword accumulate wrote back");
	chk_busy_refuse: assert property (op_valid && busy_r |=> !gpr_we_r && !rsv_exc_r)
		else $error("request taken while busy");
endmodule

bind mda_unit mda_unit_monitor mda_unit_monitor_inst (.sys_clk, .nrst, .op_valid, .op_code,
	.dest_idx, .mode_64, .kernel_mode, .gpr_we_r, .gpr_idx_r, .rsv_exc_r, .busy_r,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o_r);

// file: sim/mda_pipe.sv
// Pipeline issue model that feeds operations to the unit.
`timescale 1ns/1ps
module mda_pipe
	import mda_pkg::*;
(
	// Clock and status
	input wire logic    sys_clk,
	input wire logic    busy_r,
	// Issue port
	output logic        op_valid,
	output mda_op_t     op_code,
	output logic [63:0] source_a_reg,
	output logic [63:0] source_b_reg,
	output logic [4:0]  dest_idx,
	output logic        clamp_en,
	output logic        upper_select,
	output logic        unsigned_select,
	output logic        mode_64,
	output logic        kernel_mode
);
	int gap = 0;
	initial begin
		op_code = MDA_OP_READ_TOP;
		{op_valid, source_a_reg, source_b_reg, dest_idx} = '0;
		{clamp_en, upper_select, unsigned_select, mode_64, kernel_mode} = '0;
	end
	function automatic logic [63:0] sx(input logic [63:0] v, input int n, input logic s);
		if (s) return $signed(v << n) >>> n;
		return (v << n) >> n;
	endfunction
	// ----------------------------------------------------------------------
	// One operation; f is {skip busy, 64-bit, kernel, clamp, upper, unsigned}.
	// ----------------------------------------------------------------------
	task automatic issue(input mda_op_t op, input logic [63:0] a, b, input logic [5:0] f);
		int n;
		logic s;
		logic dv;
		dv = op inside {MDA_OP_WORD_QUOTIENT, MDA_OP_UNSIGNED_WORD_QUOTIENT};
		n = (op == MDA_OP_DOUBLE_MUL_ACCUM) ? (f[2] ? 48 : 32) : dv ? 32 : 0;
		if (op == MDA_OP_HALFWORD_MUL_ACCUM) n = 48;
		s = !(op == MDA_OP_DOUBLE_MUL_ACCUM && f[0]);
		// Two quiet slots before a divide keep earlier result reads clean.
		if (dv) repeat (2) @(posedge sys_clk);
		if (!f[5]) repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		while (!f[5] && busy_r !== 1'b0) @(posedge sys_clk);
		op_valid <= 1'b1;
		op_code <= op;
		source_a_reg <= sx(a, n, s);
		source_b_reg <= sx(b, n, s);
		{mode_64, kernel_mode, clamp_en, upper_select, unsigned_select} <= f[4:0];
		dest_idx <= dest_idx + 5'h1;
		gap = dv ? 36 : 0;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		// Operands do not stand once the request is gone.
		{source_a_reg, source_b_reg} <= ~{source_a_reg, source_b_reg};
	endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the multiply, divide and accumulate unit.
`timescale 1ns/1ps
`include "mda_cfg.svh"
module tb_top
	import mda_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        op_valid, clamp_en, upper_select, unsigned_select, mode_64, kernel_mode;
	logic        gpr_we_r, rsv_exc_r, busy_r, irq_r, wb_ack_o_r;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [4:0]  dest_idx, gpr_idx_r;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o_r, q;
	logic [63:0] source_a_reg, source_b_reg, gpr_data_r, a, b, r, t, e;
	mda_op_t     op_code;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          cyc_n = 0;
	mda_unit mda_unit_inst (.*);
	mda_pipe mda_pipe_inst (.*);
	always #10 sys_clk = ~sys_clk;
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] ad, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, ad, 4'hf, d};
		do @(posedge sys_clk); while (wb_ack_o_r !== 1'b1);
		q = wb_dat_o_r;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic rd64(input logic [7:0] ad);
		wb(ad, 1'b0, 32'h0);
		r[31:0] = q;
		wb(ad + 8'h4, 1'b0, 32'h0);
		r[63:32] = q;
	endtask
	function automatic logic [127:0] div_exp(input logic [63:0] x, y, input logic u);
		logic [31:0] qq, rr;
		if (u) {qq, rr} = {x[31:0] / y[31:0], x[31:0] % y[31:0]};
		else {qq, rr} = {$signed(x[31:0]) / $signed(y[31:0]), $signed(x[31:0]) % $signed(y[31:0])};
		return {{32{rr[31]}}, rr, {32{qq[31]}}, qq};
	endfunction
	function automatic logic [63:0] mac_exp(input logic [63:0] bt, x, y, input logic [2:0] f);
		logic signed [63:0] s;
		if (!f[2] && f[0]) return bt + x[31:0] * y[31:0];
		if (!f[2]) return $signed(bt) + $signed(x[31:0]) * $signed(y[31:0]);
		if (f[0]) begin
			s = bt[31:0] + x[15:0] * y[15:0];
			return s > 64'hffff_ffff ? `MDA_UNS_LIMIT : s;
		end
		s = $signed(bt[31:0]) + $signed(x[15:0]) * $signed(y[15:0]);
		if (s > 64'sh7fff_ffff) return `MDA_POS_LIMIT;
		return s < -64'sh8000_0000 ? `MDA_NEG_LIMIT : s;
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc_n++;
		if (cyc_n == 6000) begin
			bad_count++;
			finish_test;
		end
	end
	initial begin
		void'($urandom(83593));
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		wb(`MDA_ADR_STATUS, 1'b0, 32'h0);
		check(q, 64'h0);
		wb(`MDA_ADR_MASK, 1'b1, 32'h7);
		wb(`MDA_ADR_MASK, 1'b0, 32'h0);
		check(q, 64'h7);
		wb(8'h40, 1'b0, 32'h0);
		check(q, 64'h0);
		for (int i = 0; i < 8; i++) begin
			a = {$urandom, $urandom};
			b = {$urandom, $urandom} >> ($urandom % 60) | 64'h1;
			mda_pipe_inst.issue(i[0] ? MDA_OP_UNSIGNED_WORD_QUOTIENT : MDA_OP_WORD_QUOTIENT,
				a, b, 6'h10);
			if (i == 0) mda_pipe_inst.issue(MDA_OP_DOUBLE_MUL_ACCUM, a, b, 6'h30);
			do @(posedge sys_clk); while (busy_r !== 1'b0);
			@(posedge sys_clk);
			check(irq_r, 64'h1);
			{t, e} = div_exp(a, b, i[0]);
			rd64(`MDA_ADR_BOT_LO);
			check(r, e);
			rd64(`MDA_ADR_TOP_LO);
			check(r, t);
			wb(`MDA_ADR_STATUS, 1'b0, 32'h0);
			check(q, 64'h1);
			repeat (2) @(posedge sys_clk);
			check(irq_r, 64'h0);
		end
		for (int i = 0; i < 16; i++) begin
			{a, b, t, e} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, 64'h0};
			e = {$urandom, $urandom};
			if (i[2]) e = i[0] ? {32'h0, e[31:0]} : {{32{e[31]}}, e[31:0]};
			if (i > 11) begin
				a = i[0] ? 64'hffff : 64'h7fff;
				b = i[0] ? 64'hffff : i[1] ? 64'h7fff : 64'h8000;
				e = i[0] ? 64'hffff_ff00 : i[1] ? 64'h7fff_ff00 : 64'hffff_ffff_8000_0100;
			end
			mda_pipe_inst.issue(MDA_OP_WRITE_TOP, t, 64'h0, 6'h10);
			mda_pipe_inst.issue(MDA_OP_WRITE_BOTTOM, e, 64'h0, 6'h10);
			mda_pipe_inst.issue(MDA_OP_DOUBLE_MUL_ACCUM, a, b,
				{1'b0, i > 7 ? 2'b01 : 2'b10, i[2:0]});
			e = mac_exp(e, a, b, i[2:0]);
			@(posedge sys_clk);
			check(gpr_we_r, 64'h1);
			check(gpr_idx_r, dest_idx);
			check(gpr_data_r, i[1] ? t : e);
			rd64(`MDA_ADR_BOT_LO);
			check(r, e);
		end
		wb(`MDA_ADR_STATUS, 1'b0, 32'h0);
		wb(`MDA_ADR_MASK, 1'b1, 32'h4);
		{a, b, e} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		mda_pipe_inst.issue(MDA_OP_WRITE_BOTTOM, e, 64'h0, 6'h10);
		mda_pipe_inst.issue(MDA_OP_HALFWORD_MUL_ACCUM, a, b, 6'h08);
		e = $signed(e) + $signed(a[15:0]) * $signed(b[15:0]);
		repeat (2) @(posedge sys_clk);
		check(irq_r, 64'h0);
		rd64(`MDA_ADR_BOT_LO);
		check(r, e);
		mda_pipe_inst.issue(MDA_OP_HALFWORD_MUL_ACCUM, a, b, 6'h00);
		@(posedge sys_clk);
		check(rsv_exc_r, 64'h1);
		mda_pipe_inst.issue(MDA_OP_DOUBLE_MUL_ACCUM, a, b, 6'h00);
		@(posedge sys_clk);
		check(rsv_exc_r, 64'h1);
		rd64(`MDA_ADR_BOT_LO);
		check(r, e);
		check(irq_r, 64'h1);
		wb(`MDA_ADR_STATUS, 1'b0, 32'h0);
		check(q[2], 64'h1);
		finish_test;
	end
endmodule
